//--- tuc_top.sv
`timescale 1ns/1ns
// Behaviour
// - With rewind and unload inputs both high, no rewind indication and no forced reverse drive.
// - Rewind input low raises rewind-active and requests high-speed reverse ramp.
// - Rewind or unload low forces the ramp request into reverse.
// - Online only after load complete plus a switch press, or by the auto option; a press toggles while online or load complete.
// - A press while online clears the online flag.
// - Online lamp follows the online flag.
// - Online status line is online flag and secondary qualifier.
// - Reset switch pulses general reset lines low and clears online.
// - Force-offline input clears online through the reset path.
// - Control reset low pulse during load clears online.
// - Auto option: strobe high while load-to-marker set and no rewind.
// - Auto option: strobe fall on load-to-marker clearing, not on a rewind start, sets online when currently offline.
// - Online-qualify strap: address recognised only while online; else always.
// - When addressed drive primary select, data select and selected lamp.
// - Secondary qualifier is held high or follows primary, by strap.
// - Tertiary select follows raw decode or secondary qualifier, by strap.
// - Ready only when online, selected, not rewinding or loading, interlocks made.
// - Ready and forward command gives forward ramp request while held.
// - Ready and reverse command gives reverse ramp request at sync speed.
// - Jog switch drives manual motion only while offline and locally ready.
// - Manual forward inhibited at end-of-tape marker.
// - Manual reverse inhibited at beginning-of-tape marker.
module tuc_top
    import tuc_pkg::*;
#(
    parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Operator switches, raw
    input wire logic ONLINE_SW_IN,
    input wire logic RESET_SW_IN,
    input wire logic JOG_FWD_SW_IN,
    input wire logic JOG_REV_SW_IN,
    // Transport state
    input wire logic LOAD_COMPLETE_IN,
    input wire logic LOAD_TO_MARKER_FLAG_IN,
    input wire logic REWIND_IN_PROGRESS_IN,
    input wire logic LOADING_IN,
    input wire logic INTERLOCKS_MADE_IN,
    input wire logic EOT_SENSED_IN,
    input wire logic BOT_SENSED_IN,
    input wire logic CONTROL_RESET_N_IN,
    input wire logic REWIND_COMMAND_N_IN,
    input wire logic UNLOAD_COMMAND_N_IN,
    // Controller interface
    input wire logic UNIT_SELECT_IN,
    input wire logic FORCE_OFFLINE_IN,
    input wire logic SYNC_FORWARD_CMD_IN,
    input wire logic SYNC_REVERSE_CMD_IN,
    output logic ONLINE_STATUS_OUT,
    output logic READY_STATUS_OUT,
    // Select outputs and lamps
    output logic PRIMARY_SELECT_OUT,
    output logic DATA_SELECT_OUT,
    output logic SECONDARY_SELECT_QUALIFIER_OUT,
    output logic TERTIARY_SELECT_OUT,
    output logic ONLINE_LAMP_OUT,
    output logic RESET_LAMP_OUT,
    // Reset lines and ramp requests
    output logic GENERAL_RESET_N_OUT,
    output logic REWIND_ACTIVE_OUT,
    output logic HIGH_SPEED_REV_OUT,
    output logic RAMP_FWD_OUT,
    output logic RAMP_REV_OUT,
    output logic AUTO_ONLINE_STROBE_OUT
);

    // =========================================================
    // Functions
    // =========================================================
    // Debounce step: returns next count and stable level packed
    function automatic logic [DB_CNT_W:0] db_step(
        input logic raw, input logic stable, input logic [DB_CNT_W-1:0] cnt);
        logic [DB_CNT_W-1:0] c;
        logic s;
        c = cnt;
        s = stable;
        if (raw == stable) begin
            c = '0;
        end else if (cnt >= DB_CNT_W'(DEBOUNCE_CNT - 1)) begin
            c = '0;
            s = raw;
        end else begin
            c = cnt + DB_CNT_W'(1);
        end
        return {s, c};
    endfunction

    // =========================================================
    // Switch synchronisers and debouncers
    // =========================================================
    logic [2:0] sw_meta_r, sw_meta_nxt;
    logic [2:0] sw_sync_r, sw_sync_nxt;
    logic [2:0] sw_stable_r, sw_stable_nxt;
    logic [DB_CNT_W-1:0] db_cnt_r [3];
    logic [DB_CNT_W-1:0] db_cnt_nxt [3];
    logic [2:0] sw_press;

    // Sync, debounce, one pulse per press
    always_comb begin
        logic [DB_CNT_W:0] st;
        st = '0;
        sw_meta_nxt = {JOG_REV_SW_IN, RESET_SW_IN, ONLINE_SW_IN};
        sw_sync_nxt = sw_meta_r;
        for (int i = 0; i < 3; i++) begin
            st = db_step(sw_sync_r[i], sw_stable_r[i], db_cnt_r[i]);
            sw_stable_nxt[i] = st[DB_CNT_W];
            db_cnt_nxt[i] = st[DB_CNT_W-1:0];
        end
        sw_press = sw_stable_nxt & ~sw_stable_r;
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sw_meta_r <= 3'h0;
            sw_sync_r <= 3'h0;
            sw_stable_r <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                db_cnt_r[i] <= '0;
            end
        end else begin
            sw_meta_r <= sw_meta_nxt;
            sw_sync_r <= sw_sync_nxt;
            sw_stable_r <= sw_stable_nxt;
            db_cnt_r <= db_cnt_nxt;
        end
    end

    // Jog forward switch: separate level path, debounced
    logic jog_meta_r, jog_sync_r, jog_fwd_r;
    logic [DB_CNT_W-1:0] jog_cnt_r;
    logic jog_fwd_nxt;
    logic [DB_CNT_W-1:0] jog_cnt_nxt;
    logic jog_rev_lvl;

    always_comb begin
        logic [DB_CNT_W:0] st;
        st = db_step(jog_sync_r, jog_fwd_r, jog_cnt_r);
        jog_fwd_nxt = st[DB_CNT_W];
        jog_cnt_nxt = st[DB_CNT_W-1:0];
        jog_rev_lvl = sw_stable_r[2];
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            jog_meta_r <= 1'b0;
            jog_sync_r <= 1'b0;
            jog_fwd_r <= 1'b0;
            jog_cnt_r <= '0;
        end else begin
            jog_meta_r <= JOG_FWD_SW_IN;
            jog_sync_r <= jog_meta_r;
            jog_fwd_r <= jog_fwd_nxt;
            jog_cnt_r <= jog_cnt_nxt;
        end
    end

    // =========================================================
    // APB control register
    // =========================================================
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [31:0] status_word;
    logic apb_access;
    logic addr_ok;

    // Decode, write in the access phase, read capture in the setup phase
    always_comb begin
        apb_access = PSEL_IN & PENABLE_IN;
        addr_ok = (PADDR_IN == ADDR_CTRL) || (PADDR_IN == ADDR_STATUS);
        ctrl_nxt = ctrl_r;
        prdata_nxt = prdata_r;
        if (apb_access && PWRITE_IN && PADDR_IN == ADDR_CTRL) begin
            ctrl_nxt = PWDATA_IN[3:0];
        end
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            case (PADDR_IN)
                ADDR_CTRL: prdata_nxt = {28'h0000000, ctrl_r};
                ADDR_STATUS: prdata_nxt = status_word;
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl_r <= CTRL_RESET;
            prdata_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = apb_access & ~addr_ok;
    assign PRDATA_OUT = prdata_r;

    // =========================================================
    // On-line flag, reset path and auto on-line
    // =========================================================
    logic online_r, online_nxt;
    logic strobe_r, strobe_nxt;
    logic reset_path;
    logic raw_decode, primary, secondary, tertiary, ready;
    tuc_motion_t motion_r, motion_nxt;

    always_comb begin
        // Reset switch, controller force and load reset share one path
        reset_path = sw_press[1] | FORCE_OFFLINE_IN | ~CONTROL_RESET_N_IN;
        strobe_nxt = ctrl_r[CTRL_AUTO_ONLINE] & LOAD_TO_MARKER_FLAG_IN
                     & ~REWIND_IN_PROGRESS_IN;
        online_nxt = online_r;
        if (reset_path) begin
            online_nxt = 1'b0;
        end else if (sw_press[0] && (online_r || LOAD_COMPLETE_IN)) begin
            online_nxt = ~online_r;
        end else if (strobe_r && !strobe_nxt && !online_r && !LOAD_TO_MARKER_FLAG_IN
                     && ctrl_r[CTRL_AUTO_ONLINE]) begin
            // Only a cleared marker flag counts, not a rewind start
            online_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            online_r <= 1'b0;
            strobe_r <= 1'b0;
        end else begin
            online_r <= online_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    // =========================================================
    // Address selection and ready
    // =========================================================
    always_comb begin
        raw_decode = UNIT_SELECT_IN;
        primary = raw_decode & (online_r | ~ctrl_r[CTRL_STRAP_ONL_QUAL]);
        secondary = ctrl_r[CTRL_STRAP_SEC_HIGH] ? 1'b1 : primary;
        tertiary = ctrl_r[CTRL_STRAP_TER_RAW] ? raw_decode : secondary;
        ready = online_r & primary & ~REWIND_IN_PROGRESS_IN & ~LOADING_IN
                & INTERLOCKS_MADE_IN;
    end

    // =========================================================
    // Motion request
    // =========================================================
    logic local_ready, rew_or_unl;

    always_comb begin
        local_ready = ~REWIND_IN_PROGRESS_IN & ~LOADING_IN & INTERLOCKS_MADE_IN;
        rew_or_unl = ~REWIND_COMMAND_N_IN | ~UNLOAD_COMMAND_N_IN;
        motion_nxt = TUC_MOT_NONE;
        if (rew_or_unl) begin
            motion_nxt = TUC_MOT_REV;
        end else if (ready) begin
            case ({SYNC_FORWARD_CMD_IN, SYNC_REVERSE_CMD_IN})
                2'b10: motion_nxt = TUC_MOT_FWD;
                2'b01: motion_nxt = TUC_MOT_REV;
                default: motion_nxt = TUC_MOT_NONE;
            endcase
        end else if (!online_r && local_ready) begin
            // Manual jog while off line, marker guarded
            case ({jog_fwd_r, jog_rev_lvl})
                2'b10: motion_nxt = EOT_SENSED_IN ? TUC_MOT_NONE : TUC_MOT_FWD;
                2'b01: motion_nxt = BOT_SENSED_IN ? TUC_MOT_NONE : TUC_MOT_REV;
                default: motion_nxt = TUC_MOT_NONE;
            endcase
        end
    end

    // Output flops
    logic rew_act_r, gen_rst_n_r;
    logic [6:0] sel_r;

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            motion_r <= TUC_MOT_NONE;
            rew_act_r <= 1'b0;
            gen_rst_n_r <= 1'b1;
            sel_r <= 7'h00;
        end else begin
            motion_r <= motion_nxt;
            rew_act_r <= ~REWIND_COMMAND_N_IN;
            gen_rst_n_r <= ~sw_press[1];
            sel_r <= {online_nxt & secondary, ready, primary, primary, secondary,
                      tertiary, online_nxt};
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign ONLINE_LAMP_OUT = online_r;
    assign ONLINE_STATUS_OUT = sel_r[6];
    assign READY_STATUS_OUT = sel_r[5];
    assign PRIMARY_SELECT_OUT = sel_r[4];
    assign DATA_SELECT_OUT = sel_r[3] & sel_r[4];
    assign RESET_LAMP_OUT = sel_r[4];
    assign SECONDARY_SELECT_QUALIFIER_OUT = sel_r[2];
    assign TERTIARY_SELECT_OUT = sel_r[1];
    assign GENERAL_RESET_N_OUT = gen_rst_n_r;
    assign REWIND_ACTIVE_OUT = rew_act_r;
    assign HIGH_SPEED_REV_OUT = rew_act_r;
    assign RAMP_FWD_OUT = (motion_r == TUC_MOT_FWD);
    assign RAMP_REV_OUT = (motion_r == TUC_MOT_REV);
    assign AUTO_ONLINE_STROBE_OUT = strobe_r;

    // Status word for software
    assign status_word = {23'h000000, strobe_r, RAMP_REV_OUT, RAMP_FWD_OUT, rew_act_r,
                          sel_r[5], sel_r[1], sel_r[2], sel_r[4], sel_r[0]};

endmodule

//--- tuc_pkg.sv
package tuc_pkg;
    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_FREQ_HZ = 20000000;
    localparam int DEBOUNCE_TIME_US = 5000;
    localparam int DEBOUNCE_CYCLES = (CLK_FREQ_HZ / 1000000) * DEBOUNCE_TIME_US;
    localparam int DB_CNT_W = 17;

    // =========================================================
    // APB register map
    // =========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // CTRL field positions
    localparam int CTRL_STRAP_ONL_QUAL = 0;
    localparam int CTRL_STRAP_SEC_HIGH = 1;
    localparam int CTRL_STRAP_TER_RAW = 2;
    localparam int CTRL_AUTO_ONLINE = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // STATUS field positions
    localparam int ST_ONLINE = 0;
    localparam int ST_PRIMARY = 1;
    localparam int ST_SECONDARY = 2;
    localparam int ST_TERTIARY = 3;
    localparam int ST_READY = 4;
    localparam int ST_REWIND = 5;
    localparam int ST_FWD = 6;
    localparam int ST_REV = 7;
    localparam int ST_AUTO_STB = 8;

    // Motion request encoding
    typedef enum logic [1:0] {
        TUC_MOT_NONE,
        TUC_MOT_FWD,
        TUC_MOT_REV
    } tuc_motion_t;
endpackage

//--- tuc_ctl_model.sv
`timescale 1ns/1ns
module tuc_ctl_model (
    // Clock and requests from the bench
    input wire logic clk_in,
    input wire logic sel_req_in,
    input wire logic fwd_req_in,
    input wire logic rev_req_in,
    input wire logic offl_req_in,
    // Lines toward the unit
    output logic sel_out,
    output logic fwd_out,
    output logic rev_out,
    output logic offl_out
);
    // ==========================================================
    // Controller lines
    // ==========================================================
    // Forward and reverse commands only go out while the unit is addressed
    always_ff @(posedge clk_in) begin
        sel_out <= sel_req_in;
        fwd_out <= fwd_req_in & sel_req_in;
        rev_out <= rev_req_in & sel_req_in;
        offl_out <= offl_req_in;
    end
endmodule

//--- tuc_top_props.sv
`timescale 1ns/1ns
module tuc_top_props (
    // Watched ports
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic FORCE_OFFLINE_IN,
    input wire logic CONTROL_RESET_N_IN,
    input wire logic REWIND_COMMAND_N_IN,
    input wire logic UNLOAD_COMMAND_N_IN,
    input wire logic SYNC_FORWARD_CMD_IN,
    input wire logic SYNC_REVERSE_CMD_IN,
    input wire logic EOT_SENSED_IN,
    input wire logic BOT_SENSED_IN,
    input wire logic ONLINE_STATUS_OUT,
    input wire logic ONLINE_LAMP_OUT,
    input wire logic GENERAL_RESET_N_OUT,
    input wire logic REWIND_ACTIVE_OUT,
    input wire logic HIGH_SPEED_REV_OUT,
    input wire logic RAMP_FWD_OUT,
    input wire logic RAMP_REV_OUT,
    input wire logic AUTO_ONLINE_STROBE_OUT
);
    // ==========================================================
    // Properties
    // ==========================================================
    wire cmd_idle = REWIND_COMMAND_N_IN && UNLOAD_COMMAND_N_IN;
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    rew_idle_a: assert property (cmd_idle |=> !REWIND_ACTIVE_OUT)
        else $error("rewind active while idle");
    rew_start_a: assert property (!REWIND_COMMAND_N_IN |=> REWIND_ACTIVE_OUT && HIGH_SPEED_REV_OUT)
        else $error("rewind did not start");
    rev_force_a: assert property (!cmd_idle |=> RAMP_REV_OUT && !RAMP_FWD_OUT)
        else $error("reverse not forced");
    status_gate_a: assert property (ONLINE_STATUS_OUT |-> ONLINE_LAMP_OUT || $past(ONLINE_LAMP_OUT))
        else $error("online status while offline");
    gen_pulse_a: assert property ($fell(GENERAL_RESET_N_OUT) |=> GENERAL_RESET_N_OUT)
        else $error("reset pulse too long");
    rst_clear_a: assert property (!GENERAL_RESET_N_OUT |-> ##[0:1] !ONLINE_LAMP_OUT)
        else $error("reset pulse left unit online");
    force_off_a: assert property (FORCE_OFFLINE_IN |-> ##[1:3] !ONLINE_LAMP_OUT)
        else $error("force offline ignored");
    ctl_rst_a: assert property (!CONTROL_RESET_N_IN |-> ##[1:3] !ONLINE_LAMP_OUT)
        else $error("control reset ignored");
    both_cmd_a: assert property (SYNC_FORWARD_CMD_IN && SYNC_REVERSE_CMD_IN && ONLINE_LAMP_OUT
        && cmd_idle |=> !RAMP_FWD_OUT && !RAMP_REV_OUT)
        else $error("motion on conflicting commands");
    eot_stop_a: assert property (EOT_SENSED_IN && !ONLINE_LAMP_OUT && cmd_idle |=> !RAMP_FWD_OUT)
        else $error("forward at end marker");
    bot_stop_a: assert property (BOT_SENSED_IN && !ONLINE_LAMP_OUT && cmd_idle |=> !RAMP_REV_OUT)
        else $error("reverse at start marker");
    // Main scenarios reached
    cov_rew_c: cover property ($rose(REWIND_ACTIVE_OUT));
    cov_jog_c: cover property (RAMP_FWD_OUT && !ONLINE_LAMP_OUT);
    cov_auto_c: cover property ($fell(AUTO_ONLINE_STROBE_OUT));
endmodule
bind tuc_top tuc_top_props tuc_top_props_inst (.CLK_SYS_IN, .RESET_IN, .FORCE_OFFLINE_IN,
    .CONTROL_RESET_N_IN, .REWIND_COMMAND_N_IN, .UNLOAD_COMMAND_N_IN, .SYNC_FORWARD_CMD_IN,
    .SYNC_REVERSE_CMD_IN, .EOT_SENSED_IN, .BOT_SENSED_IN, .ONLINE_STATUS_OUT, .ONLINE_LAMP_OUT,
    .GENERAL_RESET_N_OUT, .REWIND_ACTIVE_OUT, .HIGH_SPEED_REV_OUT, .RAMP_FWD_OUT, .RAMP_REV_OUT,
    .AUTO_ONLINE_STROBE_OUT);

//--- tuc_top_tb.sv
`timescale 1ns/1ns
module tuc_top_tb;
    import tuc_pkg::*;
    // ==========================================================
    // Stimulus and wiring
    // ==========================================================
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, rd;
    logic [3:0] sw = 4'h0;
    logic lc = 0, ldm = 0, rip = 0, ldg = 0, il = 1, eot = 0, bot = 0;
    logic crn = 1, rwn = 1, unn = 1, sr = 0, fr = 0, rr = 0, orq = 0, er;
    wire [31:0] prd;
    wire prdy, perr, sel, fwd, rev, offl, ons, rdy, ps, ds, ss, ts, olamp, rlamp, grn;
    wire ra, hsr, rf, rv, aos;
    int n_errors = 0, checked = 0, nlow = 0;
    tuc_top #(.DEBOUNCE_CNT(4)) tuc_top_inst (.CLK_SYS_IN(clk), .RESET_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
        .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .ONLINE_SW_IN(sw[0]),
        .RESET_SW_IN(sw[1]), .JOG_FWD_SW_IN(sw[2]), .JOG_REV_SW_IN(sw[3]),
        .LOAD_COMPLETE_IN(lc), .LOAD_TO_MARKER_FLAG_IN(ldm), .REWIND_IN_PROGRESS_IN(rip),
        .LOADING_IN(ldg), .INTERLOCKS_MADE_IN(il), .EOT_SENSED_IN(eot), .BOT_SENSED_IN(bot),
        .CONTROL_RESET_N_IN(crn), .REWIND_COMMAND_N_IN(rwn), .UNLOAD_COMMAND_N_IN(unn),
        .UNIT_SELECT_IN(sel), .FORCE_OFFLINE_IN(offl), .SYNC_FORWARD_CMD_IN(fwd),
        .SYNC_REVERSE_CMD_IN(rev), .ONLINE_STATUS_OUT(ons), .READY_STATUS_OUT(rdy),
        .PRIMARY_SELECT_OUT(ps), .DATA_SELECT_OUT(ds), .SECONDARY_SELECT_QUALIFIER_OUT(ss),
        .TERTIARY_SELECT_OUT(ts), .ONLINE_LAMP_OUT(olamp), .RESET_LAMP_OUT(rlamp),
        .GENERAL_RESET_N_OUT(grn), .REWIND_ACTIVE_OUT(ra), .HIGH_SPEED_REV_OUT(hsr),
        .RAMP_FWD_OUT(rf), .RAMP_REV_OUT(rv), .AUTO_ONLINE_STROBE_OUT(aos));
    tuc_ctl_model tuc_ctl_model_inst (.clk_in(clk), .sel_req_in(sr), .fwd_req_in(fr),
        .rev_req_in(rr), .offl_req_in(orq), .sel_out(sel), .fwd_out(fwd), .rev_out(rev),
        .offl_out(offl));
    // Clock and count of reset pulse cycles
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (!rst && grn === 1'b0) nlow++;
    end
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pen <= 0; pwr <= wr; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    // Switch held past the debounce span, then released
    task automatic press(input int i);
        sw[i] <= 1; w(10); sw[i] <= 0; w(10);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs;
        apb(0, ADDR_CTRL, 0); chk(rd, 32'h0);
        apb(1, ADDR_CTRL, 32'hF); apb(0, ADDR_CTRL, 0); chk(rd, 32'hF);
        apb(1, 8'h08, 32'hFF); apb(0, 8'h08, 0); chk({rd, er}, {32'h0, 1'b1});
        apb(1, ADDR_CTRL, 0);
    endtask
    task automatic t_online;
        press(0); chk(olamp, 0);
        lc <= 1; press(0); chk(olamp, 1);
        press(0); chk(olamp, 0);
    endtask
    task automatic t_select;
        sr <= 1; w(4); chk({ps, ds, rlamp, ss}, 4'hF);
        chk(ons, 0); press(0); chk(ons, 1);
        apb(1, ADDR_CTRL, 32'h5); press(0); chk({ps, ts}, 2'b01);
        apb(1, ADDR_CTRL, 32'h2); sr <= 0; w(4); chk({ps, ss}, 2'b01);
        press(0); chk(ons, 1);
        press(0);
        apb(1, ADDR_CTRL, 0);
    endtask
    task automatic t_motion;
        press(0); sr <= 1; w(4); chk(rdy, 1);
        fr <= 1; w(4); chk({rf, rv}, 2'b10);
        apb(0, ADDR_STATUS, 0); chk(rd, 32'h5F);
        rr <= 1; w(4); chk({rf, rv}, 2'b00);
        fr <= 0; w(4); chk({rf, rv}, 2'b01);
        rr <= 0; ldg <= 1; w(4); chk(rdy, 0);
        ldg <= 0; w(2);
    endtask
    task automatic t_rewind;
        rwn <= 0; w(3); chk({ra, hsr, rf, rv}, 4'b1101);
        rwn <= 1; unn <= 0; w(3); chk({ra, rv}, 2'b01);
        unn <= 1; w(3); chk({ra, rv}, 2'b00);
    endtask
    task automatic t_reset;
        nlow = 0; press(1); chk({nlow, olamp}, 33'h2);
        press(0); orq <= 1; w(4); orq <= 0; chk(olamp, 0);
        press(0); crn <= 0; w(1); crn <= 1; w(3); chk(olamp, 0);
    endtask
    task automatic t_jog;
        sw[2] <= 1; w(12); chk({rf, rv}, 2'b10);
        eot <= 1; w(3); chk({rf, rv}, 2'b00);
        eot <= 0; sw[2] <= 0; sw[3] <= 1; w(12); chk({rf, rv}, 2'b01);
        bot <= 1; w(3); chk({rf, rv}, 2'b00);
        bot <= 0; sr <= 0; press(0); chk({rf, rv}, 2'b00);
        sw[3] <= 0; press(0);
    endtask
    task automatic t_auto;
        apb(1, ADDR_CTRL, 32'h8); ldm <= 1; w(3); chk(aos, 1);
        rip <= 1; w(3); chk({aos, olamp}, 2'b00);
        rip <= 0; w(3);
        ldm <= 0; w(4); chk(olamp, 1);
        apb(1, ADDR_CTRL, 0);
    endtask
    // ==========================================================
    // Verdict and sequence
    // ==========================================================
    task automatic stop_test;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        w(6); rst <= 0; w(1);
        t_regs; t_online; t_select; t_motion; t_rewind; t_reset; t_jog; t_auto;
        stop_test;
    end
    initial begin
        #(3000 * 50);
        n_errors++;
        stop_test;
    end
endmodule
